/* File: rscs_pkg.sv */
package rscs_pkg;

  // Register map of the plain software port.
  localparam logic [3:0]  REG_CAUSE         = 4'h0;
  localparam logic [3:0]  REG_CLOCK         = 4'h1;
  localparam logic [15:0] CAUSE_RESET_VAL   = 16'h0003;
  localparam logic [15:0] CAUSE_WRITE_MASK  = 16'hC1FF;
  localparam logic [15:0] CAUSE_BOR_CLEAR   = 16'hC05C;

  // Bit positions inside reset_cause_status.
  localparam int B_POR      = 0;
  localparam int B_BOR      = 1;
  localparam int B_IDLE     = 2;
  localparam int B_SLEEP    = 3;
  localparam int B_WATCHDOG_TIMEOUT_FLAG     = 4;
  localparam int B_WDT_EN   = 5;
  localparam int B_INSTR    = 6;
  localparam int B_PIN      = 7;
  localparam int B_REG_KEEP = 8;
  localparam int B_BADOP    = 14;
  localparam int B_TRAP     = 15;

  // Layout of the synchronised pin vector.
  localparam int SB_BOR     = 0;
  localparam int SB_CLEAR_N = 1;
  localparam int SB_OSC     = 2;
  localparam int SB_CLKSW   = 3;
  localparam int SB_WDT_FUS = 4;
  localparam int SB_REG_EN  = 5;
  localparam int SB_XTAL    = 6;
  localparam int SB_OSC_SELECT_FUSES   = 7;
  localparam int SYNC_W     = 10;
  localparam logic [SYNC_W-1:0] SYNC_RESET_VAL = 10'h002;

  // Oscillator selection codes.
  localparam logic [2:0] OSC_FRC    = 3'h0;
  localparam logic [2:0] OSC_FRCPLL = 3'h1;
  localparam logic [2:0] OSC_PRI    = 3'h2;
  localparam logic [2:0] OSC_PRIPLL = 3'h3;
  localparam logic [2:0] OSC_SEC    = 3'h4;

  // Nominal times in ns and the derived cycle counts at 100 MHz.
  localparam int CLK_PERIOD_NS      = 10;
  localparam int T_POR_NS           = 10000;
  localparam int T_STARTUP_REG_NS   = 20000;
  localparam int T_STARTUP_NOREG_NS = 64000000;
  localparam int T_RST_NS           = 20000;
  localparam int T_LOCK_NS          = 20000;
  localparam int T_MONITOR_NS       = 100000;
  localparam int POR_CYC     = (T_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SU_REG_CYC  = (T_STARTUP_REG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SU_LONG_CYC = (T_STARTUP_NOREG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYC     = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_CYC    = (T_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MON_CYC     = (T_MONITOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] OST_LAST = 10'h3FF;

  typedef enum logic [2:0] {
    PH_POWER   = 3'b000,
    PH_STARTUP = 3'b001,
    PH_HOLD    = 3'b011,
    PH_RUN     = 3'b010,
    PH_WAKE    = 3'b110
  } rscs_phase_t;

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic              osc_prev;
    rscs_phase_t       phase;
    logic [23:0]       tmr;
    logic [9:0]        ost_cnt;
    logic              ost_done;
    logic [15:0]       lock_cnt;
    logic              clk_ok;
    logic              clk_rel;
    logic [15:0]       mon_cnt;
    logic              mon_wait;
    logic              mon_en;
    logic [15:0]       cause;
    logic [2:0]        cur_osc;
    logic [15:0]       rdata;
    logic              sys_rst;
  } rscs_state_t;

  typedef struct packed {
    logic       xtal;
    logic       pll;
  } rscs_osc_kind_t;

endpackage

/* File: rscs_reset_combiner.sv */
`timescale 1ns/1ps
// What this block does
// - Any active source asserts system reset
// - Each reset kind sets its cause flag
// - Power-on clears all flags except power-on and brown-out
// - Software writes flags; never causes reset
// - Trap flag set by conflict, power clears
// - Bad opcode/pointer flag, power clears
// - Pin flag cleared by power-on only
// - Instruction flag, cleared by power events
// - Watchdog flag; power-save and power clear
// - Sleep and idle flags from power-save
// - Brown-out flag set by brown-out/power-on
// - Power-on flag set only by power-on
// - Soft watchdog enable, fuse overrides
// - Regulator keep-awake during sleep bit
// - Bits 13 to 9 read zero
// - Power resets load fuses, others keep
// - Switching off: resets from run load fuses
// - Power-on release after three summed delays
// - Start-up delay short/long; short one on wake
// - Other resets hold only state time
// - Crystal waits 1024 oscillator periods
// - PLL adds lock time after crystal count
// - Monitor starts late for crystal or PLL
module rscs_reset_combiner
  import rscs_pkg::*;
#(
  parameter int P_POR_CYC     = POR_CYC,
  parameter int P_SU_REG_CYC  = SU_REG_CYC,
  parameter int P_SU_LONG_CYC = SU_LONG_CYC,
  parameter int P_RST_CYC     = RST_CYC,
  parameter int P_LOCK_CYC    = LOCK_CYC,
  parameter int P_MON_CYC     = MON_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  input  wire logic        i_brownout,
  input  wire logic        i_external_clear_pin_n,
  input  wire logic        i_osc_clk,
  input  wire logic        i_clock_switch_en,
  input  wire logic        i_watchdog_fuse_enable,
  input  wire logic        i_regulator_en,
  input  wire logic        i_primary_is_crystal,
  input  wire logic [2:0]  i_osc_select_fuses,
  input  wire logic        i_reset_instr,
  input  wire logic        i_watchdog_timeout,
  input  wire logic        i_trap_conflict,
  input  wire logic        i_bad_opcode_pointer,
  input  wire logic        i_power_save_sleep,
  input  wire logic        i_power_save_idle,
  input  wire logic        i_wake,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [15:0]      o_rdata,
  output logic             o_system_reset_out,
  output logic             o_sys_clk_release,
  output logic             o_clock_failure_monitor_en,
  output logic             o_watchdog_en,
  output logic             o_regulator_sleep_keep,
  output logic [2:0]       o_current_osc_field
);

  // Terminal counts, all tunable through the parameters.
  localparam logic [23:0] C_POR  = 24'(P_POR_CYC - 1);
  localparam logic [23:0] C_SUR  = 24'(P_SU_REG_CYC - 1);
  localparam logic [23:0] C_SUL  = 24'(P_SU_LONG_CYC - 1);
  localparam logic [23:0] C_RST  = 24'(P_RST_CYC - 1);
  localparam logic [15:0] C_LOCK = 16'(P_LOCK_CYC - 1);
  localparam logic [15:0] C_MON  = 16'(P_MON_CYC - 1);

  function automatic rscs_osc_kind_t osc_kind(input logic [2:0] sel, input logic xtal_pri);
    rscs_osc_kind_t k;
    k.xtal = ((sel == OSC_PRI || sel == OSC_PRIPLL) && xtal_pri) || (sel == OSC_SEC);
    k.pll  = (sel == OSC_FRCPLL) || (sel == OSC_PRIPLL);
    return k;
  endfunction

  rscs_state_t    s_q;
  rscs_state_t    s_d;
  logic           bor_s;
  logic           clear_s;
  logic           src_other;
  logic           cause_wr;
  logic [23:0]    su_end;
  rscs_osc_kind_t kind;

  assign bor_s     = s_q.sync2[SB_BOR];
  assign clear_s   = !s_q.sync2[SB_CLEAR_N];
  assign src_other = clear_s | i_reset_instr | i_watchdog_timeout | i_trap_conflict
                   | i_bad_opcode_pointer;
  assign cause_wr  = i_wr && (i_addr == REG_CAUSE);
  assign su_end    = s_q.sync2[SB_REG_EN] ? C_SUR : C_SUL;
  assign kind      = osc_kind(s_q.cur_osc, s_q.sync2[SB_XTAL]);

  always_comb begin
    s_d       = s_q;
    s_d.sync1 = {i_osc_select_fuses, i_primary_is_crystal, i_regulator_en,
                 i_watchdog_fuse_enable, i_clock_switch_en, i_osc_clk,
                 i_external_clear_pin_n, i_brownout};
    s_d.sync2    = s_q.sync1;
    s_d.osc_prev = s_q.sync2[SB_OSC];
    s_d.tmr      = s_q.tmr + 24'h000001;

    // Release sequencing of the system reset.
    unique case (s_q.phase)
      PH_POWER: begin
        s_d.cur_osc = s_q.sync2[SB_OSC_SELECT_FUSES +: 3];
        if (s_q.tmr == C_POR) begin
          s_d.phase = PH_STARTUP;
          s_d.tmr   = 24'h000000;
        end
      end
      PH_STARTUP: begin
        if (s_q.tmr == su_end) begin
          s_d.phase = PH_HOLD;
          s_d.tmr   = 24'h000000;
        end
      end
      PH_HOLD: begin
        if (src_other) begin
          s_d.tmr = 24'h000000;
        end else if (s_q.tmr == C_RST) begin
          s_d.phase = PH_RUN;
        end
      end
      PH_RUN: begin
        s_d.tmr = 24'h000000;
        if (src_other) begin
          s_d.phase = PH_HOLD;
          if (!s_q.sync2[SB_CLKSW]) begin
            s_d.cur_osc = s_q.sync2[SB_OSC_SELECT_FUSES +: 3];
          end
        end else if (i_wake && s_q.sync2[SB_REG_EN]) begin
          s_d.phase = PH_WAKE;
        end
      end
      PH_WAKE: begin
        if (src_other) begin
          s_d.phase = PH_HOLD;
          s_d.tmr   = 24'h000000;
        end else if (s_q.tmr == C_SUR) begin
          s_d.phase = PH_RUN;
        end
      end
      default: begin
        s_d.phase = PH_POWER;
        s_d.tmr   = 24'h000000;
      end
    endcase

    // Oscillator start-up count and PLL lock wait, in parallel with the reset delays.
    // They wait out the power-on delay so that the selected source has left the synchroniser.
    if (s_q.phase == PH_POWER) begin
      s_d.ost_done = s_q.ost_done;
    end else if (!s_q.ost_done) begin
      if (!kind.xtal) begin
        s_d.ost_done = 1'b1;
      end else if (s_q.sync2[SB_OSC] && !s_q.osc_prev) begin
        s_d.ost_cnt = s_q.ost_cnt + 10'h001;
        if (s_q.ost_cnt == OST_LAST) begin
          s_d.ost_done = 1'b1;
        end
      end
    end else if (!s_q.clk_ok) begin
      if (!kind.pll || s_q.lock_cnt == C_LOCK) begin
        s_d.clk_ok = 1'b1;
      end else begin
        s_d.lock_cnt = s_q.lock_cnt + 16'h0001;
      end
    end

    // Clock failure monitoring waits after the first release only for crystal or PLL.
    if (s_q.mon_wait && s_q.phase == PH_RUN) begin
      if (!(kind.xtal || kind.pll) || s_q.mon_cnt == C_MON) begin
        s_d.mon_wait = 1'b0;
        s_d.mon_en   = 1'b1;
      end else begin
        s_d.mon_cnt = s_q.mon_cnt + 16'h0001;
      end
    end

    // Cause flags: software write, then hardware clears, then hardware sets.
    if (cause_wr) begin
      s_d.cause = i_wdata & CAUSE_WRITE_MASK;
    end
    if (i_power_save_sleep || i_power_save_idle) begin
      s_d.cause[B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
    end
    if (bor_s) begin
      s_d.cause = s_d.cause & ~CAUSE_BOR_CLEAR;
    end
    if (bor_s) begin
      s_d.cause[B_BOR] = 1'b1;
    end
    if (clear_s) begin
      s_d.cause[B_PIN] = 1'b1;
    end
    if (i_reset_instr) begin
      s_d.cause[B_INSTR] = 1'b1;
    end
    if (i_watchdog_timeout) begin
      s_d.cause[B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
    end
    if (i_trap_conflict) begin
      s_d.cause[B_TRAP] = 1'b1;
    end
    if (i_bad_opcode_pointer) begin
      s_d.cause[B_BADOP] = 1'b1;
    end
    if (i_power_save_sleep) begin
      s_d.cause[B_SLEEP] = 1'b1;
    end
    if (i_power_save_idle) begin
      s_d.cause[B_IDLE] = 1'b1;
    end

    // A brown-out restarts the whole power-on style sequence and clock selection.
    if (bor_s) begin
      s_d.phase    = PH_POWER;
      s_d.tmr      = 24'h000000;
      s_d.ost_cnt  = 10'h000;
      s_d.ost_done = 1'b0;
      s_d.lock_cnt = 16'h0000;
      s_d.clk_ok   = 1'b0;
      s_d.mon_cnt  = 16'h0000;
      s_d.mon_wait = 1'b1;
      s_d.mon_en   = 1'b0;
    end

    s_d.sys_rst = (s_d.phase != PH_RUN) && (s_d.phase != PH_WAKE);
    s_d.clk_rel = s_d.clk_ok && (s_d.phase != PH_WAKE);

    if (i_rd && i_addr == REG_CAUSE) begin
      s_d.rdata = s_q.cause;
    end else if (i_rd && i_addr == REG_CLOCK) begin
      s_d.rdata = {9'h000, s_q.cur_osc, s_q.mon_en, s_q.clk_ok, s_q.ost_done,
                   s_q.sync2[SB_WDT_FUS]};
    end else begin
      s_d.rdata = 16'h0000;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q          <= '0;
      s_q.sync1    <= SYNC_RESET_VAL;
      s_q.sync2    <= SYNC_RESET_VAL;
      s_q.phase    <= PH_POWER;
      s_q.mon_wait <= 1'b1;
      s_q.cause    <= CAUSE_RESET_VAL;
      s_q.sys_rst  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata                    = s_q.rdata;
  assign o_system_reset_out         = s_q.sys_rst;
  assign o_sys_clk_release          = s_q.clk_rel;
  assign o_clock_failure_monitor_en = s_q.mon_en;
  assign o_watchdog_en              = s_q.sync2[SB_WDT_FUS] | s_q.cause[B_WDT_EN];
  assign o_regulator_sleep_keep     = s_q.cause[B_REG_KEEP];
  assign o_current_osc_field        = s_q.cur_osc;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  a_source_asserts_reset: assert property (src_other || bor_s |=> o_system_reset_out ##1 o_system_reset_out)
    else $error("System reset not asserted after a reset source.");
  a_pin_flag_set: assert property (clear_s |=> s_q.cause[B_PIN])
    else $error("Pin flag not set by clear pin.");
  a_trap_flag_set: assert property (i_trap_conflict |=> s_q.cause[B_TRAP])
    else $error("Trap flag not set by conflict.");
  a_bor_clears_flags: assert property (bor_s && !i_reset_instr && !i_bad_opcode_pointer
    |=> s_q.cause[B_BOR] && !s_q.cause[B_INSTR] && !s_q.cause[B_BADOP])
    else $error("Brown-out did not clear or set the right flags.");
  a_bor_keeps_pin: assert property (bor_s && s_q.cause[B_PIN] && !cause_wr |=> s_q.cause[B_PIN])
    else $error("Brown-out cleared the pin flag.");
  a_write_no_reset: assert property (cause_wr && s_q.phase == PH_RUN && !src_other && !bor_s
    |=> !o_system_reset_out)
    else $error("Flag write caused a reset.");
  a_unimpl_zero: assert property (i_rd && i_addr == REG_CAUSE |=> o_rdata[13:9] == 5'h00)
    else $error("Unimplemented bits read non-zero.");
  a_power_save_instruction_clears_wdt: assert property (i_power_save_sleep && !i_watchdog_timeout && !cause_wr
    && !bor_s
    |=> !s_q.cause[B_WATCHDOG_TIMEOUT_FLAG] && s_q.cause[B_SLEEP])
    else $error("Power-save did not clear watchdog flag.");
  a_hold_release: assert property (s_q.phase == PH_HOLD && s_q.tmr == C_RST && !src_other
    && !bor_s |=> !o_system_reset_out)
    else $error("Reset not released after state reset time.");
  a_startup_end: assert property (s_q.phase == PH_STARTUP && s_q.tmr == su_end && !bor_s
    |=> s_q.phase == PH_HOLD && o_system_reset_out)
    else $error("Start-up delay did not end on time.");
  a_osc_kept: assert property (s_q.phase == PH_RUN && src_other && s_q.sync2[SB_CLKSW]
    && !bor_s |=> $stable(o_current_osc_field))
    else $error("Oscillator field changed on a non-power reset.");
  a_fuse_forces_wdt: assert property (s_q.sync2[SB_WDT_FUS] |-> o_watchdog_en)
    else $error("Watchdog disabled while fuse forces it on.");

  c_pin_reset: cover property (s_q.phase == PH_RUN ##1 clear_s ##[1:10] o_system_reset_out);
  c_wake: cover property (s_q.phase == PH_WAKE ##[1:10] s_q.phase == PH_RUN);
  c_monitor_on: cover property ($rose(o_clock_failure_monitor_en));
  c_clock_release: cover property ($rose(o_sys_clk_release));

endmodule

/* File: rscs_partner.sv */
`timescale 1ns/1ps
// Stands in for the reset sources, the core's power-save decoder and the crystal.
// The oscillator runs free at a quarter of the system clock rate.
module rscs_partner (
  input  wire logic       i_clk_sys,
  input  wire logic       i_go,
  input  wire logic [2:0] i_kind,
  output logic            o_osc_clk,
  output logic [6:0]      o_ev,
  output logic            o_pin_n
);
  logic [1:0] div_q;
  logic       go_q;

  assign o_osc_clk = div_q[1];

  initial begin
    div_q   = 2'h0;
    go_q    = 1'b0;
    o_ev    = 7'h00;
    o_pin_n = 1'b1;
  end

  // Same-clock events are one-cycle pulses; the clear pin is held low two cycles.
  always @(posedge i_clk_sys) begin
    div_q   <= div_q + 2'h1;
    go_q    <= i_go;
    o_ev    <= (i_go && i_kind != 3'h4) ? 7'(1 << i_kind) : 7'h00;
    o_pin_n <= !((i_go || go_q) && i_kind == 3'h4);
  end
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import rscs_pkg::*;
  localparam int PR = 20;
  localparam int SR = 20;
  localparam int SL = 50;
  localparam int RC = 30;
  localparam int LK = 20;
  localparam int MC = 40;
  logic        clk = 1'b0, rst_n = 1'b0, bo = 1'b0, csw = 1'b1, wfuse = 1'b1;
  logic        reg_en = 1'b1, xtal = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0, rd_pend = 1'b0;
  logic [2:0]  fuse = OSC_PRIPLL, kind = 3'h0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] expq[$];
  logic [15:0] exp_bit[5] = '{16'h0040, 16'h0010, 16'h8000, 16'h4000, 16'h0080};
  int          num_errors = 0, n_tests = 0, cyc = 0;
  wire         osc, pin_n, srst, crel, mon, wden, rkeep;
  wire  [6:0]  ev;
  wire  [15:0] rdata;
  wire  [2:0]  oscf;

  initial begin
    forever #5 clk = ~clk;
  end

  rscs_partner u_rscs_partner (.i_clk_sys(clk), .i_go(go), .i_kind(kind), .o_osc_clk(osc),
    .o_ev(ev), .o_pin_n(pin_n));

  rscs_reset_combiner #(.P_POR_CYC(PR), .P_SU_REG_CYC(SR), .P_SU_LONG_CYC(SL),
    .P_RST_CYC(RC), .P_LOCK_CYC(LK), .P_MON_CYC(MC)) u_rscs_reset_combiner (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_brownout(bo), .i_external_clear_pin_n(pin_n),
    .i_osc_clk(osc), .i_clock_switch_en(csw), .i_watchdog_fuse_enable(wfuse),
    .i_regulator_en(reg_en), .i_primary_is_crystal(xtal), .i_osc_select_fuses(fuse),
    .i_reset_instr(ev[0]), .i_watchdog_timeout(ev[1]), .i_trap_conflict(ev[2]),
    .i_bad_opcode_pointer(ev[3]), .i_power_save_sleep(ev[5]), .i_power_save_idle(ev[6]),
    .i_wake(1'b0), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_system_reset_out(srst), .o_sys_clk_release(crel), .o_clock_failure_monitor_en(mon),
    .o_watchdog_en(wden), .o_regulator_sleep_keep(rkeep), .o_current_osc_field(oscf));

  task automatic end_of_test();
    $display("errors=%0d comparisons=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic inrange(input int n, input int lo, input int hi);
    chk(16'(n >= lo && n <= hi), 16'h0001);
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken at the next edge.
  always @(posedge clk) begin
    if (rd_pend) begin
      chk(rdata, expq.pop_front());
    end
    rd_pend <= rd;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd16(input logic [3:0] a, input logic [15:0] e);
    expq.push_back(e);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    rd <= 1'b0;
    wr <= 1'b0;
    go <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  task automatic fire(input int k);
    kind <= 3'(k);
    go <= 1'b1;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic sig(input int k);
    return (k == 0) ? srst : (k == 1) ? crel : mon;
  endfunction

  task automatic wfor(input int k, input logic v, output int n);
    n = 0;
    while (sig(k) !== v && n < 8000) begin
      @(posedge clk);
      n++;
    end
  endtask

  initial begin
    int n, m, q;
    logic [15:0] d;
    void'($urandom(32'hBF3F800F));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wfor(0, 1'b0, n);
    inrange(n, PR + SR + RC, PR + SR + RC + 8);
    chk(16'(oscf), 16'(OSC_PRIPLL));
    chk(16'(wden), 16'h0001);
    rd16(REG_CAUSE, CAUSE_RESET_VAL);
    idle(1);
    wfor(1, 1'b1, m);
    inrange(n + m, 1023 * 4 + LK, 1024 * 4 + LK + 40);
    wfor(2, 1'b1, q);
    inrange(2 + m + q, MC, 8000);
    wr16(REG_CAUSE, 16'hFFFF);
    rd16(REG_CAUSE, 16'hC1FF);
    rd16(4'h7, 16'h0000);
    idle(2);
    chk(16'({srst, wden, rkeep}), 16'h0003);
    wfuse <= 1'b0;
    wr16(REG_CAUSE, 16'h0000);
    idle(4);
    chk(16'({wden, rkeep}), 16'h0000);
    repeat (4) begin
      d = 16'($urandom);
      wr16(REG_CAUSE, d);
      rd16(REG_CAUSE, d & CAUSE_WRITE_MASK);
    end
    wfuse <= 1'b1;
    fuse <= OSC_FRC;
    for (int i = 0; i < 5; i++) begin
      wr16(REG_CAUSE, 16'h0000);
      fire(i);
      idle(1);
      wfor(0, 1'b1, n);
      wfor(0, 1'b0, n);
      inrange(n, RC, RC + 8);
      rd16(REG_CAUSE, exp_bit[i]);
      idle(1);
      chk(16'(oscf), 16'(OSC_PRIPLL));
    end
    wr16(REG_CAUSE, 16'h0010);
    fire(5);
    idle(3);
    rd16(REG_CAUSE, 16'h0008);
    wr16(REG_CAUSE, 16'h0010);
    fire(6);
    idle(3);
    rd16(REG_CAUSE, 16'h0004);
    wr16(REG_CAUSE, 16'hC0DC);
    reg_en <= 1'b0;
    fuse <= OSC_PRI;
    bo <= 1'b1;
    idle(6);
    bo <= 1'b0;
    wfor(0, 1'b0, n);
    inrange(n, PR + SL + RC, PR + SL + RC + 10);
    rd16(REG_CAUSE, 16'h0082);
    idle(1);
    chk(16'(oscf), 16'(OSC_PRI));
    reg_en <= 1'b1;
    csw <= 1'b0;
    fuse <= OSC_SEC;
    idle(4);
    fire(0);
    idle(1);
    wfor(0, 1'b1, n);
    wfor(0, 1'b0, n);
    chk(16'(oscf), 16'(OSC_SEC));
    idle(2);
    end_of_test();
  end
endmodule
